// ### verilog/tcs_top.sv
// conversion sequencer with result, status and limit registers
// assumes the host framing logic turns bus cycles into reg_wr / reg_rd strobes on clk,
// and an analog front end that integrates while adc_integrate is high on adc_clk
`timescale 1ns/1ps

// Functional notes
// - convert continuously at rate or on one-shot
// - fastest rate stores sign plus seven integer bits
// - slower rates add three fraction bits
// - integration period short or long by rate
// - every channel converted whether connected or not
// - free run when halt zero, or one-shot
// - order remote1, local, remote1, remote2
// - all results readable after sequence ends
// - busy flag set during a sequence
// - previous results held while converting
// - alarms assert above programmed thresholds
// - open-drain active-low alarms, released otherwise
module tcs_top #(
	parameter int INTEG_SHORT_CYC = tcs_pkg::INTEG_SHORT_CYC,
	parameter int INTEG_LONG_CYC = tcs_pkg::INTEG_LONG_CYC,
	parameter int SEQ_BASE_CYC = tcs_pkg::SEQ_BASE_CYC
) (
	// system
	input wire logic clk,
	input wire logic reset,
	// host register port
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// front end link
	input wire logic adc_clk,
	input wire logic [tcs_pkg::RESULT_W-1:0] adc_result,
	output logic adc_integrate,
	output logic [1:0] adc_channel,
	output logic adc_long_period,
	// over-temperature pins, open drain
	input wire logic overtemp_alarm_first_in,
	output logic overtemp_alarm_first_out,
	output logic overtemp_alarm_first_oe,
	input wire logic overtemp_alarm_second_in,
	output logic overtemp_alarm_second_out,
	output logic overtemp_alarm_second_oe
);

	// elaboration checks: counts must be positive and fit the shared timer width
	if (INTEG_SHORT_CYC < 1 || INTEG_LONG_CYC < INTEG_SHORT_CYC) begin
		$error("tcs_top: bad integration counts");
	end
	if (INTEG_LONG_CYC >= (1 << tcs_pkg::TIMER_W)) begin
		$error("tcs_top: integration count does not fit the timer");
	end
	if (SEQ_BASE_CYC < 1 || SEQ_BASE_CYC >= (1 << tcs_pkg::TIMER_W)) begin
		$error("tcs_top: sequence base does not fit the timer");
	end

	localparam logic [tcs_pkg::TIMER_W-1:0] SHORT_T = INTEG_SHORT_CYC[tcs_pkg::TIMER_W-1:0];
	localparam logic [tcs_pkg::TIMER_W-1:0] LONG_T = INTEG_LONG_CYC[tcs_pkg::TIMER_W-1:0];
	localparam logic [tcs_pkg::TIMER_W-1:0] BASE_T = SEQ_BASE_CYC[tcs_pkg::TIMER_W-1:0];

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// channel visited at each step of a sequence
	function automatic logic [1:0] step_channel(input logic [1:0] step);
		unique case (step)
			2'h0: step_channel = tcs_pkg::CH_REMOTE1;
			2'h1: step_channel = tcs_pkg::CH_LOCAL;
			2'h2: step_channel = tcs_pkg::CH_REMOTE1;
			2'h3: step_channel = tcs_pkg::CH_REMOTE2;
		endcase
	endfunction

	// signed integer part above limit
	function automatic logic above(input tcs_pkg::tcs_result_t r, input logic [7:0] lim);
		above = $signed(r[tcs_pkg::RESULT_W-1:tcs_pkg::FRAC_W]) > $signed(lim);
	endfunction

	function automatic logic [7:0] frac_byte(input tcs_pkg::tcs_result_t r);
		frac_byte = {r[tcs_pkg::FRAC_W-1:0], 5'h00};
	endfunction

	// ----------------------------------------------------------------
	// system clock state
	// ----------------------------------------------------------------
	typedef struct packed {
		tcs_pkg::tcs_state_e state;
		logic [1:0] step;
		logic [tcs_pkg::TIMER_W-1:0] integ_cnt;
		logic [tcs_pkg::TIMER_W-1:0] ivl_cnt;
		logic seq_pend;
		logic busy;
		logic long_seq;
		logic req_t;
		logic [2:0] ack_sync;
		logic ack_seen;
		tcs_pkg::tcs_result_t sh_local;
		tcs_pkg::tcs_result_t sh_r1;
		tcs_pkg::tcs_result_t sh_r2;
		tcs_pkg::tcs_result_t vis_local;
		tcs_pkg::tcs_result_t vis_r1;
		tcs_pkg::tcs_result_t vis_r2;
		logic halt;
		logic [2:0] rate;
		logic [7:0] lim1;
		logic [7:0] lim2;
		logic [7:0] rdata;
		logic ot1_oe;
		logic ot2_oe;
		logic [2:0] pin1_sync;
		logic [2:0] pin2_sync;
		logic pin1_lvl;
		logic pin2_lvl;
	} tcs_sys_s;

	// ----------------------------------------------------------------
	// link clock state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [2:0] req_sync;
		logic req_seen;
		logic integ;
		logic [1:0] chan;
		logic long_p;
		logic ack_t;
		tcs_pkg::tcs_result_t data;
	} tcs_link_s;

	tcs_sys_s s_q;
	tcs_sys_s s_d;
	tcs_link_s l_q;
	tcs_link_s l_d;

	logic ack_evt;
	logic [tcs_pkg::TIMER_W-1:0] ivl_limit;
	logic [tcs_pkg::TIMER_W-1:0] integ_limit;
	logic fastest;

	// ----------------------------------------------------------------
	// system clock logic
	// ----------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		fastest = s_q.rate >= tcs_pkg::RATE_FASTEST;
		// interval between sequence starts halves with each rate step up to RATE_FASTEST, then stays at that value
		ivl_limit = BASE_T >> (fastest ? tcs_pkg::RATE_FASTEST : s_q.rate);
		integ_limit = s_q.long_seq ? LONG_T : SHORT_T;

		// ack toggle counts once the second and third stages agree
		s_d.ack_sync = {s_q.ack_sync[1:0], l_q.ack_t};
		ack_evt = (s_q.ack_sync[1] == s_q.ack_sync[2]) && (s_q.ack_sync[2] != s_q.ack_seen);
		if (ack_evt) begin
			s_d.ack_seen = s_q.ack_sync[2];
		end

		// alarm pin readback
		s_d.pin1_sync = {s_q.pin1_sync[1:0], overtemp_alarm_first_in};
		s_d.pin2_sync = {s_q.pin2_sync[1:0], overtemp_alarm_second_in};
		if (s_q.pin1_sync[1] == s_q.pin1_sync[2]) begin
			s_d.pin1_lvl = s_q.pin1_sync[2];
		end
		if (s_q.pin2_sync[1] == s_q.pin2_sync[2]) begin
			s_d.pin2_lvl = s_q.pin2_sync[2];
		end

		// free-running interval timer
		if (s_q.ivl_cnt < ivl_limit) begin
			s_d.ivl_cnt = s_q.ivl_cnt + 1'b1;
		end
		if (!s_q.halt && s_q.ivl_cnt + 1'b1 >= ivl_limit) begin
			s_d.seq_pend = 1'b1;
		end

		// register writes
		if (reg_wr) begin
			unique case (reg_addr)
				tcs_pkg::OFS_CONFIG: s_d.halt = reg_wdata[tcs_pkg::CFG_HALT_BIT];
				tcs_pkg::OFS_RATE: s_d.rate = reg_wdata[2:0];
				tcs_pkg::OFS_LIMIT_FIRST: s_d.lim1 = reg_wdata;
				tcs_pkg::OFS_LIMIT_SECOND: s_d.lim2 = reg_wdata;
				tcs_pkg::OFS_ONE_SHOT: s_d.seq_pend = 1'b1;
				default: ;
			endcase
		end

		// sequencer
		unique case (s_q.state)
			tcs_pkg::TCS_IDLE: begin
				if (s_q.seq_pend) begin
					// every channel runs each sequence, connected or not
					// a one-shot landing on the start cycle is kept: the set wins
					s_d.seq_pend = reg_wr && reg_addr == tcs_pkg::OFS_ONE_SHOT;
					s_d.busy = 1'b1;
					s_d.step = 2'h0;
					s_d.long_seq = !fastest;
					s_d.ivl_cnt = '0;
					s_d.integ_cnt = '0;
					s_d.req_t = !s_q.req_t;
					s_d.state = tcs_pkg::TCS_INTEG;
				end
			end
			tcs_pkg::TCS_INTEG: begin
				s_d.integ_cnt = s_q.integ_cnt + 1'b1;
				if (s_q.integ_cnt + 1'b1 >= integ_limit) begin
					s_d.req_t = !s_q.req_t;
					s_d.state = tcs_pkg::TCS_WAIT_ACK;
				end
			end
			tcs_pkg::TCS_WAIT_ACK: begin
				if (ack_evt) begin
					// link data is held stable until the next request toggles
					unique case (step_channel(s_q.step))
						tcs_pkg::CH_LOCAL: s_d.sh_local = l_q.data;
						tcs_pkg::CH_REMOTE1: s_d.sh_r1 = l_q.data;
						default: s_d.sh_r2 = l_q.data;
					endcase
					if (s_q.step == 2'h3) begin
						// publish all channels at once; old values stand until now
						s_d.vis_local = s_q.sh_local;
						s_d.vis_r1 = s_q.sh_r1;
						s_d.vis_r2 = l_q.data;
						s_d.busy = 1'b0;
						s_d.state = tcs_pkg::TCS_IDLE;
					end else begin
						s_d.step = s_q.step + 1'b1;
						s_d.integ_cnt = '0;
						s_d.req_t = !s_q.req_t;
						s_d.state = tcs_pkg::TCS_INTEG;
					end
				end
			end
		endcase

		// fastest rate: fraction forced to zero so only whole degrees are stored
		if (s_q.state == tcs_pkg::TCS_WAIT_ACK && ack_evt && !s_q.long_seq) begin
			unique case (step_channel(s_q.step))
				tcs_pkg::CH_LOCAL: s_d.sh_local[tcs_pkg::FRAC_W-1:0] = '0;
				tcs_pkg::CH_REMOTE1: s_d.sh_r1[tcs_pkg::FRAC_W-1:0] = '0;
				default: ;
			endcase
			if (s_q.step == 2'h3) begin
				s_d.vis_r2[tcs_pkg::FRAC_W-1:0] = '0;
			end
		end

		// alarms follow the published results and limits
		s_d.ot1_oe = above(s_q.vis_local, s_q.lim1) || above(s_q.vis_r1, s_q.lim1)
			|| above(s_q.vis_r2, s_q.lim1);
		s_d.ot2_oe = above(s_q.vis_local, s_q.lim2) || above(s_q.vis_r1, s_q.lim2)
			|| above(s_q.vis_r2, s_q.lim2);

		// register reads
		if (reg_rd) begin
			unique case (reg_addr)
				tcs_pkg::OFS_PRIMARY_FIRST:
					s_d.rdata = s_q.vis_local[tcs_pkg::RESULT_W-1:tcs_pkg::FRAC_W];
				tcs_pkg::OFS_PRIMARY_SECOND:
					s_d.rdata = s_q.vis_r1[tcs_pkg::RESULT_W-1:tcs_pkg::FRAC_W];
				tcs_pkg::OFS_PRIMARY_THIRD:
					s_d.rdata = s_q.vis_r2[tcs_pkg::RESULT_W-1:tcs_pkg::FRAC_W];
				tcs_pkg::OFS_FRACTION_FIRST: s_d.rdata = frac_byte(s_q.vis_r1);
				tcs_pkg::OFS_FRACTION_SECOND: s_d.rdata = frac_byte(s_q.vis_local);
				tcs_pkg::OFS_FRACTION_THIRD: s_d.rdata = frac_byte(s_q.vis_r2);
				tcs_pkg::OFS_STATUS1: begin
					s_d.rdata = 8'h00;
					s_d.rdata[tcs_pkg::STAT_BUSY_BIT] = s_q.busy;
					s_d.rdata[tcs_pkg::STAT_PIN1_BIT] = !s_q.pin1_lvl;
					s_d.rdata[tcs_pkg::STAT_PIN2_BIT] = !s_q.pin2_lvl;
				end
				tcs_pkg::OFS_CONFIG: begin
					s_d.rdata = 8'h00;
					s_d.rdata[tcs_pkg::CFG_HALT_BIT] = s_q.halt;
				end
				tcs_pkg::OFS_RATE: s_d.rdata = {5'h00, s_q.rate};
				tcs_pkg::OFS_LIMIT_FIRST: s_d.rdata = s_q.lim1;
				tcs_pkg::OFS_LIMIT_SECOND: s_d.rdata = s_q.lim2;
				default: s_d.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			s_q <= '0;
			s_q.state <= tcs_pkg::TCS_IDLE;
			s_q.rate <= tcs_pkg::RATE_RESET;
			s_q.lim1 <= tcs_pkg::LIMIT_FIRST_RESET;
			s_q.lim2 <= tcs_pkg::LIMIT_SECOND_RESET;
			s_q.pin1_sync <= 3'h7;
			s_q.pin2_sync <= 3'h7;
			s_q.pin1_lvl <= 1'b1;
			s_q.pin2_lvl <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// link clock logic
	// ----------------------------------------------------------------
	// each request toggle alternately opens and closes one integration;
	// channel and period were settled on clk well before the toggle arrives
	always_comb begin
		l_d = l_q;
		l_d.req_sync = {l_q.req_sync[1:0], s_q.req_t};
		if (l_q.req_sync[1] == l_q.req_sync[2] && l_q.req_sync[2] != l_q.req_seen) begin
			l_d.req_seen = l_q.req_sync[2];
			if (!l_q.integ) begin
				l_d.integ = 1'b1;
				l_d.chan = step_channel(s_q.step);
				l_d.long_p = s_q.long_seq;
			end else begin
				l_d.integ = 1'b0;
				l_d.data = adc_result;
				l_d.ack_t = !l_q.ack_t;
			end
		end
	end

	always_ff @(posedge adc_clk or posedge reset) begin
		if (reset) begin
			l_q <= '0;
		end else begin
			l_q <= l_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign reg_rdata = s_q.rdata;
	assign adc_integrate = l_q.integ;
	assign adc_channel = l_q.chan;
	assign adc_long_period = l_q.long_p;
	// pins only ever pull low; the enable carries the alarm
	assign overtemp_alarm_first_out = s_q.busy & 1'b0;
	assign overtemp_alarm_first_oe = s_q.ot1_oe;
	assign overtemp_alarm_second_out = s_q.busy & 1'b0;
	assign overtemp_alarm_second_oe = s_q.ot2_oe;

endmodule

// ### verilog/tcs_pkg.sv
// constants, codes and types shared by the conversion sequencer
// assumes a 10 MHz system clock and an 11-bit signed result from the front end
package tcs_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_KHZ = 10000;
	localparam int INTEG_SHORT_US = 62500;
	localparam int INTEG_LONG_US = 125000;
	localparam int SEQ_BASE_US = 4000000;
	localparam int INTEG_SHORT_CYC = INTEG_SHORT_US * (CLK_KHZ / 1000);
	localparam int INTEG_LONG_CYC = INTEG_LONG_US * (CLK_KHZ / 1000);
	localparam int SEQ_BASE_CYC = SEQ_BASE_US * (CLK_KHZ / 1000);
	localparam int TIMER_W = 26;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_PRIMARY_FIRST = 8'h00;
	localparam logic [7:0] OFS_PRIMARY_SECOND = 8'h01;
	localparam logic [7:0] OFS_STATUS1 = 8'h02;
	localparam logic [7:0] OFS_CONFIG = 8'h03;
	localparam logic [7:0] OFS_RATE = 8'h04;
	localparam logic [7:0] OFS_ONE_SHOT = 8'h0F;
	localparam logic [7:0] OFS_FRACTION_FIRST = 8'h10;
	localparam logic [7:0] OFS_FRACTION_SECOND = 8'h11;
	localparam logic [7:0] OFS_LIMIT_FIRST = 8'h20;
	localparam logic [7:0] OFS_LIMIT_SECOND = 8'h21;
	localparam logic [7:0] OFS_PRIMARY_THIRD = 8'h22;
	localparam logic [7:0] OFS_FRACTION_THIRD = 8'h23;

	// ----------------------------------------------------------------
	// fields and reset values
	// ----------------------------------------------------------------
	localparam int CFG_HALT_BIT = 6;
	localparam int STAT_BUSY_BIT = 7;
	localparam int STAT_PIN1_BIT = 1;
	localparam int STAT_PIN2_BIT = 0;
	localparam logic [2:0] RATE_FASTEST = 3'h4;
	localparam logic [2:0] RATE_RESET = 3'h2;
	localparam logic [7:0] LIMIT_FIRST_RESET = 8'h55;
	localparam logic [7:0] LIMIT_SECOND_RESET = 8'h6E;
	localparam int FRAC_W = 3;
	localparam int RESULT_W = 11;

	// channel codes at the front end
	localparam logic [1:0] CH_LOCAL = 2'h0;
	localparam logic [1:0] CH_REMOTE1 = 2'h1;
	localparam logic [1:0] CH_REMOTE2 = 2'h2;

	typedef enum logic [1:0] {
		TCS_IDLE,
		TCS_INTEG,
		TCS_WAIT_ACK
	} tcs_state_e;

	typedef logic [RESULT_W-1:0] tcs_result_t;

endpackage

// ### tb/tcs_fe_model.sv
// front end model: returns a set temperature per channel while a step integrates
// assumes the sequencer samples adc_result on the adc_clk edge where adc_integrate falls
`timescale 1ns/1ps
module tcs_fe_model (
	// link
	input wire logic adc_clk,
	input wire logic adc_integrate,
	input wire logic [1:0] adc_channel,
	output logic [10:0] adc_result,
	// temperatures to return
	input wire logic [10:0] temp_local,
	input wire logic [10:0] temp_remote1,
	input wire logic [10:0] temp_remote2
);
	logic prev;
	logic r1_first;
	initial begin
		adc_result = 11'h000;
		prev = 1'b0;
		r1_first = 1'b0;
	end
	// first remote1 step returns the inverse, so only the second may be published
	always @(posedge adc_clk) begin
		prev <= adc_integrate;
		if (adc_integrate && !prev && adc_channel == tcs_pkg::CH_REMOTE1) r1_first <= ~r1_first;
		if (!adc_integrate) adc_result <= ~adc_result;
		else if (adc_channel == tcs_pkg::CH_LOCAL) adc_result <= temp_local;
		else if (adc_channel == tcs_pkg::CH_REMOTE1) adc_result <= r1_first ? ~temp_remote1 : temp_remote1;
		else adc_result <= temp_remote2;
	end
endmodule

// ### tb/tcs_checker_asserts.sv
// assertions on the sequencer ports
// assumes it is bound onto tcs_top
`timescale 1ns/1ps
module tcs_checker #(
	parameter int INTEG_SHORT_CYC = 20,
	parameter int INTEG_LONG_CYC = 40,
	parameter int SEQ_BASE_CYC = 2000
) (
	// system
	input wire logic clk,
	input wire logic reset,
	// host port
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	// link and pins
	input wire logic adc_clk,
	input wire logic adc_integrate,
	input wire logic [1:0] adc_channel,
	input wire logic adc_long_period,
	input wire logic overtemp_alarm_first_out,
	input wire logic overtemp_alarm_second_out
);
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// step length counted in clk cycles; crossing jitter allows a few cycles either way
	int cnt_q;
	logic [7:0] lim_q;
	logic prev_q;
	logic [1:0] step_q;
	logic [1:0] ch_exp;
	assign ch_exp = (step_q == 2'h1) ? tcs_pkg::CH_LOCAL :
		(step_q == 2'h3) ? tcs_pkg::CH_REMOTE2 : tcs_pkg::CH_REMOTE1;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cnt_q <= 0;
			lim_q <= tcs_pkg::LIMIT_FIRST_RESET;
		end else begin
			cnt_q <= adc_integrate ? cnt_q + 1 : 0;
			if (reg_wr && reg_addr == tcs_pkg::OFS_LIMIT_FIRST) lim_q <= reg_wdata;
		end
	end
	always_ff @(posedge adc_clk or posedge reset) begin
		if (reset) begin
			prev_q <= 1'b0;
			step_q <= 2'h0;
		end else begin
			prev_q <= adc_integrate;
			if (adc_integrate && !prev_q) step_q <= step_q + 2'h1;
		end
	end
	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	a_pin_never_high: assert property (@(posedge clk) disable iff (reset)
		!overtemp_alarm_first_out && !overtemp_alarm_second_out) else $error("pin driven high");
	a_rdata_holds: assert property (@(posedge clk) disable iff (reset)
		!reg_rd |=> $stable(reg_rdata)) else $error("read data moved without a read");
	a_unmapped_zero: assert property (@(posedge clk) disable iff (reset)
		reg_rd && reg_addr == 8'h05 |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
	a_limit_readback: assert property (@(posedge clk) disable iff (reset)
		reg_rd && reg_addr == tcs_pkg::OFS_LIMIT_FIRST |=> reg_rdata == $past(lim_q))
		else $error("limit readback wrong");
	a_short_integ: assert property (@(posedge clk) disable iff (reset)
		$fell(adc_integrate) && !adc_long_period |->
		cnt_q >= INTEG_SHORT_CYC - 3 && cnt_q <= INTEG_SHORT_CYC + 4) else $error("short step length");
	a_long_integ: assert property (@(posedge clk) disable iff (reset)
		$fell(adc_integrate) && adc_long_period |->
		cnt_q >= INTEG_LONG_CYC - 3 && cnt_q <= INTEG_LONG_CYC + 4) else $error("long step length");
	a_channel_steady: assert property (@(posedge adc_clk) disable iff (reset)
		adc_integrate && prev_q |-> $stable(adc_channel)) else $error("channel moved in a step");
	a_period_steady: assert property (@(posedge adc_clk) disable iff (reset)
		adc_integrate && prev_q |-> $stable(adc_long_period)) else $error("period moved in a step");
	a_step_order: assert property (@(posedge adc_clk) disable iff (reset)
		adc_integrate && !prev_q |-> adc_channel == ch_exp) else $error("channel order wrong");
endmodule

bind tcs_top tcs_checker #(.INTEG_SHORT_CYC(INTEG_SHORT_CYC), .INTEG_LONG_CYC(INTEG_LONG_CYC),
	.SEQ_BASE_CYC(SEQ_BASE_CYC)) tcs_checker_inst (.clk(clk), .reset(reset), .reg_addr(reg_addr),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
	.adc_clk(adc_clk), .adc_integrate(adc_integrate), .adc_channel(adc_channel),
	.adc_long_period(adc_long_period), .overtemp_alarm_first_out(overtemp_alarm_first_out),
	.overtemp_alarm_second_out(overtemp_alarm_second_out));

// ### tb/test_temp_conversion_sequencer.sv
// self-checking bench for the conversion sequencer with a front end model
// assumes pulled-up alarm pins and the shortened step counts below
`timescale 1ns/1ps
module test_temp_conversion_sequencer;
	logic clk, reset, adc_clk, reg_wr, reg_rd, take, exp_long, prev;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, lim1, lim2, p_loc, p_r1, p_r2, f_loc, f_r1, f_r2;
	logic [10:0] adc_result, t_loc, t_r1, t_r2;
	logic [1:0] adc_channel;
	logic [2:0] rate;
	logic adc_integrate, adc_long_period, first_out, first_oe, second_out, second_oe;
	logic [7:0] exp_q[$];
	logic [31:0] rng;
	int mismatches, num_checks, i;
	wire first_pin = first_oe ? first_out : 1'b1;
	wire second_pin = second_oe ? second_out : 1'b1;
	tcs_top #(.INTEG_SHORT_CYC(20), .INTEG_LONG_CYC(40), .SEQ_BASE_CYC(2000)) tcs_top_inst (
		.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .adc_clk(adc_clk), .adc_result(adc_result),
		.adc_integrate(adc_integrate), .adc_channel(adc_channel), .adc_long_period(adc_long_period),
		.overtemp_alarm_first_in(first_pin), .overtemp_alarm_first_out(first_out),
		.overtemp_alarm_first_oe(first_oe), .overtemp_alarm_second_in(second_pin),
		.overtemp_alarm_second_out(second_out), .overtemp_alarm_second_oe(second_oe));
	tcs_fe_model tcs_fe_model_inst (.adc_clk(adc_clk), .adc_integrate(adc_integrate),
		.adc_channel(adc_channel), .adc_result(adc_result), .temp_local(t_loc),
		.temp_remote1(t_r1), .temp_remote2(t_r2));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		adc_clk = 1'b0;
		#13;
		forever #40 adc_clk = ~adc_clk;
	end
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		num_checks++;
		if (seen !== want) begin
			mismatches++;
			$display("BAD t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] want);
		exp_q.push_back(want);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
	endtask
	// waits for n falls of adc_integrate, bounded
	task automatic wait_steps(input int n);
		int k, seen;
		seen = 0;
		for (k = 0; k < 5000 && seen < n; k++) begin
			@(posedge clk);
			if (prev && !adc_integrate) seen++;
			prev = adc_integrate;
		end
		if (seen < n) begin
			mismatches++;
			complete_run();
		end
	endtask
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	function automatic logic over(input logic [7:0] l);
		return $signed(p_loc) > $signed(l) || $signed(p_r1) > $signed(l) || $signed(p_r2) > $signed(l);
	endfunction
	// ----------------------------------------------------------------
	// monitors
	// ----------------------------------------------------------------
	always @(posedge clk) take <= reg_rd;
	always @(negedge clk) begin
		if (take) check(reg_rdata, exp_q.pop_front());
	end
	always @(posedge adc_clk) begin
		if (adc_integrate && !tcs_fe_model_inst.prev) check({7'h00, adc_long_period}, {7'h00, exp_long});
	end
	// ----------------------------------------------------------------
	// sequence
	// ----------------------------------------------------------------
	initial begin
		{reset, reg_wr, reg_rd, take, prev} = 5'h10;
		{reg_addr, reg_wdata, t_loc, t_r1, t_r2} = '0;
		{p_loc, p_r1, p_r2, f_loc, f_r1, f_r2, lim1, lim2, exp_long} = {48'h0, 8'h55, 8'h6E, 1'b0};
		rng = 32'd79278;
		mismatches = 0;
		num_checks = 0;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		rd(tcs_pkg::OFS_LIMIT_FIRST, 8'h55);
		rd(tcs_pkg::OFS_LIMIT_SECOND, 8'h6E);
		rd(tcs_pkg::OFS_RATE, 8'h02);
		rd(tcs_pkg::OFS_CONFIG, 8'h00);
		rd(8'h05, 8'h00);
		wr(tcs_pkg::OFS_PRIMARY_FIRST, 8'hA5);
		rd(tcs_pkg::OFS_PRIMARY_FIRST, 8'h00);
		rd(tcs_pkg::OFS_STATUS1, 8'h00);
		wr(tcs_pkg::OFS_CONFIG, 8'h40);
		for (i = 0; i < 4; i++) begin
			rate = (i == 0) ? 3'h0 : (i == 1) ? 3'h4 : (i == 2) ? 3'h3 : 3'h7;
			exp_long = rate < 3'h4;
			wr(tcs_pkg::OFS_RATE, {5'h00, rate});
			rng = xs(rng);
			{t_loc, t_r1, lim1} = rng[29:0];
			rng = xs(rng);
			{t_r2, lim2} = rng[18:0];
			wr(tcs_pkg::OFS_LIMIT_FIRST, lim1);
			wr(tcs_pkg::OFS_LIMIT_SECOND, lim2);
			wr(tcs_pkg::OFS_ONE_SHOT, 8'h01);
			wait_steps(1);
			rd(tcs_pkg::OFS_PRIMARY_SECOND, p_r1);
			rd(tcs_pkg::OFS_FRACTION_SECOND, f_loc);
			rd(tcs_pkg::OFS_STATUS1, {1'b1, 5'h00, over(lim1), over(lim2)});
			wait_steps(3);
			repeat (12) @(posedge clk);
			{p_loc, p_r1, p_r2} = {t_loc[10:3], t_r1[10:3], t_r2[10:3]};
			f_loc = exp_long ? {t_loc[2:0], 5'h00} : 8'h00;
			f_r1 = exp_long ? {t_r1[2:0], 5'h00} : 8'h00;
			f_r2 = exp_long ? {t_r2[2:0], 5'h00} : 8'h00;
			rd(tcs_pkg::OFS_PRIMARY_FIRST, p_loc);
			rd(tcs_pkg::OFS_PRIMARY_SECOND, p_r1);
			rd(tcs_pkg::OFS_PRIMARY_THIRD, p_r2);
			rd(tcs_pkg::OFS_FRACTION_SECOND, f_loc);
			rd(tcs_pkg::OFS_FRACTION_FIRST, f_r1);
			rd(tcs_pkg::OFS_FRACTION_THIRD, f_r2);
			rd(tcs_pkg::OFS_STATUS1, {1'b0, 5'h00, over(lim1), over(lim2)});
			rd(tcs_pkg::OFS_LIMIT_FIRST, lim1);
		end
		// free running with halt cleared: two whole sequences must follow unprompted
		rng = xs(rng);
		t_r2 = rng[10:0];
		wr(tcs_pkg::OFS_CONFIG, 8'h00);
		wait_steps(8);
		repeat (12) @(posedge clk);
		p_r2 = t_r2[10:3];
		rd(tcs_pkg::OFS_PRIMARY_THIRD, p_r2);
		repeat (4) @(posedge clk);
		complete_run();
	end
endmodule
